/* hdl/rtcirq_core.sv */
/*
 * Interrupt flags, pending summary, battery status, rate select, divider
 * control, user memory banks and square-wave output of the clock.
 * Assumes: event inputs are one-cycle pulses from logic on clk_in; power
 * and battery inputs are pins and are synchronised here; the host obeys
 * the one-cycle strobe protocol of the register port.
 */
`timescale 1ns/1ps

module rtcirq_core
	import rtcirq_pkg::*;
(
	input  wire logic       clk_in,                 // 200 MHz clock
	input  wire logic       arst_n_in,              // async reset, low
	input  wire logic [7:0] addr_in,                // register address
	input  wire logic [7:0] wr_data_in,             // write data
	input  wire logic       wr_in,                  // write strobe
	input  wire logic       rd_in,                  // read strobe
	output logic      [7:0] rd_data_out,            // read data, next cycle
	input  wire logic       alarm_match_in,         // alarm equal pulse
	input  wire logic       update_done_in,         // update end pulse
	input  wire logic       update_in_progress_in,  // update busy level
	input  wire logic       wake_event_in,          // wake-up pulse
	input  wire logic       kickstart_event_in,     // kickstart pulse
	input  wire logic       ram_clear_event_in,     // memory clear pulse
	input  wire logic       main_power_in,          // main supply present pin
	input  wire logic       auxiliary_supply_in,    // aux supply present pin
	input  wire logic       battery_good_in,        // backup supply good pin
	output logic            irq_n_out,              // interrupt, low active
	output logic            square_wave_pin_out,    // square-wave output
	output logic            osc_running_out,        // oscillator on
	output logic            chain_reset_out         // divider chain held
);

	// register state
	logic [7:0]          ctrl_a_reg;
	logic [7:0]          ctrl_b_reg;
	logic [2:0]          flags_reg;     // periodic, alarm, update-done
	logic [7:0]          ext_flags_reg;
	logic [7:0]          ext_ctrl_reg;
	logic [6:0]          ext_addr_reg;
	logic [7:0]          ram_reg [0:RAM_BYTES-1];
	logic                pending_reg;
	logic                irq_n_reg;
	logic                chain_reset_reg;
	logic [7:0]          rd_data_reg;

	// synchronisers for pins
	logic [2:0]          pin_meta_reg;
	logic [2:0]          pin_sync_reg;

	// timebase
	logic [31:0]         phase_reg;
	logic                tick_reg;
	logic [DIV_BITS-1:0] div_reg;
	logic                tap_prev_reg;
	logic                sqw_reg;

	// decoded control fields
	logic                osc_on;
	logic                chain_hold;
	logic                bank1;
	logic [3:0]          rate_select;
	logic                fast_clock_select;
	logic                aux_batt_enable;
	logic                tap;
	logic                periodic_edge;
	logic [2:0]          flags_next;
	logic [5:0]          src_flag;
	logic [5:0]          src_enable;
	logic                any_active;
	logic [7:0]          rd_value;
	logic                rd_status;
	logic                wr_ram0;
	logic                rd_ram0;
	logic [7:0]          ram0_index;

	// address hit, qualified by the bank the register lives in
	function automatic logic reg_hit(input logic [7:0] a,
			input logic [7:0] ofs, input logic need_bank1,
			input logic bank);
		reg_hit = (a == ofs) && (!need_bank1 || bank);
	endfunction

	// tap of the divider picked by the rate code, zero for code 0
	function automatic logic tap_of(input logic [3:0] code,
			input logic [DIV_BITS-1:0] d);
		logic [3:0] eff;
		eff = code;
		tap_of = 1'b0;
		if (code == 4'h1 || code == 4'h2) begin
			eff = code + 4'h7;
		end
		if (eff >= 4'h3) begin
			tap_of = d[eff - 4'h1];
		end
	endfunction

	assign osc_on            = ctrl_a_reg[CA_DV1];
	assign chain_hold        = ctrl_a_reg[CA_DV2];
	assign bank1             = ctrl_a_reg[CA_DV0];
	assign rate_select       = ctrl_a_reg[3:0];
	assign fast_clock_select = ext_ctrl_reg[EC_FAST_CLOCK_SELECT];
	assign aux_batt_enable   = ext_ctrl_reg[EC_ABE];

	// two flops on each pin before any logic reads it
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pin_meta_reg <= 3'h0;
			pin_sync_reg <= 3'h0;
		end else begin
			pin_meta_reg <= {battery_good_in, auxiliary_supply_in,
				main_power_in};
			pin_sync_reg <= pin_meta_reg;
		end
	end

	// phase accumulator makes a one-cycle tick at twice the crystal rate;
	// fractional error is under one ppm, far below any crystal tolerance
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			phase_reg <= 32'h0;
			tick_reg  <= 1'b0;
		end else begin
			{tick_reg, phase_reg} <= {1'b0, phase_reg}
				+ {1'b0, PHASE_INC[31:0]};
		end
	end

	// countdown chain: stopped with oscillator off, cleared above stage 0 when held
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			div_reg <= '0;
		end else if (!osc_on) begin
			div_reg <= div_reg;
		end else if (chain_hold) begin
			div_reg[DIV_BITS-1:1] <= '0;
			if (tick_reg) begin
				div_reg[0] <= ~div_reg[0];
			end
		end else if (tick_reg) begin
			div_reg <= div_reg + 1'b1;
		end
	end

	// rising edge of the selected tap, regardless of fast select
	assign tap           = tap_of(rate_select, div_reg);
	assign periodic_edge = tap && !tap_prev_reg;

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			tap_prev_reg <= 1'b0;
		end else begin
			tap_prev_reg <= tap;
		end
	end

	// status read is the only thing that clears these flags
	assign rd_status = rd_in && reg_hit(addr_in, OFS_STATUS, 1'b0, bank1);

	// set wins over clear: events in the read cycle survive it
	always_comb begin
		flags_next = flags_reg;
		if (rd_status) begin
			flags_next = 3'h0;
		end
		flags_next[2] = flags_next[2] | periodic_edge;
		flags_next[1] = flags_next[1] | alarm_match_in;
		flags_next[0] = flags_next[0] | update_done_in;
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			flags_reg <= 3'h0;
		end else begin
			flags_reg <= flags_next;
		end
	end

	// extended flags: write zero clears, write one keeps, event sets
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ext_flags_reg <= EXT_FLAGS_RESET;
		end else begin
			if (wr_in && reg_hit(addr_in, OFS_EXT_FLAGS, 1'b1, bank1)) begin
				ext_flags_reg[EF_WAKE] <= ext_flags_reg[EF_WAKE]
					& wr_data_in[EF_WAKE] | wake_event_in;
				ext_flags_reg[EF_KICK] <= ext_flags_reg[EF_KICK]
					& wr_data_in[EF_KICK] | kickstart_event_in;
				ext_flags_reg[EF_RCLR] <= ext_flags_reg[EF_RCLR]
					& wr_data_in[EF_RCLR] | ram_clear_event_in;
			end else begin
				ext_flags_reg[EF_WAKE] <= ext_flags_reg[EF_WAKE]
					| wake_event_in;
				ext_flags_reg[EF_KICK] <= ext_flags_reg[EF_KICK]
					| kickstart_event_in;
				ext_flags_reg[EF_RCLR] <= ext_flags_reg[EF_RCLR]
					| ram_clear_event_in;
			end
		end
	end

	// the six flag and enable pairs
	assign src_flag   = {flags_reg, ext_flags_reg[EF_WAKE],
		ext_flags_reg[EF_KICK], ext_flags_reg[EF_RCLR]};
	assign src_enable = {ctrl_b_reg[CB_PIE], ctrl_b_reg[CB_AIE],
		ctrl_b_reg[CB_UIE], ext_ctrl_reg[EC_WIE],
		ext_ctrl_reg[EC_KSE], ext_ctrl_reg[EC_RIE]};
	// level, not edge: a late enable on a stale flag fires at once
	assign any_active = |(src_flag & src_enable);

	// pin and summary bit load together so they never disagree
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pending_reg <= 1'b0;
			irq_n_reg   <= 1'b1;
		end else begin
			pending_reg <= any_active;
			irq_n_reg   <= ~any_active;
		end
	end

	// control A: update-busy bit is read-only and not stored
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ctrl_a_reg      <= CTRL_A_RESET;
			chain_reset_reg <= CTRL_A_RESET[CA_DV2] & CTRL_A_RESET[CA_DV1];
		end else if (wr_in && reg_hit(addr_in, OFS_CTRL_A, 1'b0, bank1)) begin
			ctrl_a_reg      <= {1'b0, wr_data_in[6:0]};
			// held chain only counts while the oscillator runs
			chain_reset_reg <= wr_data_in[CA_DV2]
				& wr_data_in[CA_DV1];
		end
	end

	// control B: raising the inhibit bit drops the update enable
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ctrl_b_reg <= CTRL_B_RESET;
		end else if (wr_in && reg_hit(addr_in, OFS_CTRL_B, 1'b0, bank1)) begin
			ctrl_b_reg <= wr_data_in;
			if (wr_data_in[CB_SET]) begin
				ctrl_b_reg[CB_UIE] <= 1'b0;
			end
		end
	end

	// extended control and indirect address, bank 1 only
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ext_ctrl_reg <= EXT_CTRL_RESET;
			ext_addr_reg <= 7'h00;
		end else if (wr_in) begin
			if (reg_hit(addr_in, OFS_EXT_CTRL, 1'b1, bank1)) begin
				ext_ctrl_reg <= wr_data_in & 8'hA7;
			end
			if (reg_hit(addr_in, OFS_EXT_ADDR, 1'b1, bank1)) begin
				ext_addr_reg <= wr_data_in[6:0];
			end
		end
	end

	// bank 0 memory window, shrinking to 50 bytes in bank 1
	assign ram0_index = addr_in - OFS_RAM0_FIRST;
	assign rd_ram0    = (addr_in >= OFS_RAM0_FIRST)
		&& (addr_in <= OFS_RAM0_LAST)
		&& !(bank1 && addr_in >= OFS_BANK1_FIRST);
	assign wr_ram0    = wr_in && rd_ram0;

	// user memory has no reset: it models battery-backed storage and
	// never waits on an update
	always_ff @(posedge clk_in) begin
		if (wr_ram0) begin
			ram_reg[ram0_index] <= wr_data_in;
		end else if (wr_in && reg_hit(addr_in, OFS_EXT_DATA, 1'b1,
				bank1)) begin
			ram_reg[RAM0_BYTES + int'(ext_addr_reg)] <= wr_data_in;
		end
	end

	// read multiplexer; unmapped addresses read zero
	always_comb begin
		rd_value = 8'h00;
		if (rd_ram0) begin
			rd_value = ram_reg[ram0_index];
		end else begin
			case (addr_in)
				OFS_CTRL_A: begin
					rd_value = {update_in_progress_in, ctrl_a_reg[6:0]};
				end
				OFS_CTRL_B: begin
					rd_value = ctrl_b_reg;
				end
				OFS_STATUS: begin
					// low nibble wired to zero
					rd_value = {pending_reg, flags_reg, 4'h0};
				end
				OFS_BATTERY: begin
					rd_value = {pin_sync_reg[2], 7'h00};
				end
				default: begin
					rd_value = 8'h00;
				end
			endcase
			if (bank1) begin
				case (addr_in)
					OFS_EXT_FLAGS: begin
						rd_value = ext_flags_reg;
					end
					OFS_EXT_CTRL: begin
						rd_value = ext_ctrl_reg;
					end
					OFS_EXT_ADDR: begin
						rd_value = {1'b0, ext_addr_reg};
					end
					OFS_EXT_DATA: begin
						rd_value = ram_reg[RAM0_BYTES + int'(ext_addr_reg)];
					end
					default: begin
						rd_value = rd_value;
					end
				endcase
			end
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rd_data_reg <= 8'h00;
		end else begin
			rd_data_reg <= rd_in ? rd_value : 8'h00;
		end
	end

	// square-wave pin: fast select overrides rate and enable; on backup
	// power only the crystal-rate clock may run, and only when allowed
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			sqw_reg <= 1'b0;
		end else if (!osc_on) begin
			sqw_reg <= 1'b0;
		end else if (!pin_sync_reg[0]) begin
			sqw_reg <= fast_clock_select && aux_batt_enable
				&& pin_sync_reg[1] && div_reg[0];
		end else if (fast_clock_select) begin
			sqw_reg <= div_reg[0];
		end else if (ctrl_b_reg[CB_SQUARE_WAVE_ENABLE]) begin
			sqw_reg <= tap;
		end else begin
			sqw_reg <= 1'b0;
		end
	end

	assign irq_n_out           = irq_n_reg;
	assign rd_data_out         = rd_data_reg;
	assign square_wave_pin_out = sqw_reg;
	assign osc_running_out     = ctrl_a_reg[CA_DV1];
	assign chain_reset_out     = chain_reset_reg;

endmodule

/* hdl/rtcirq_pkg.sv */
/*
 * Constants shared by the interrupt and square-wave block of the clock:
 * register offsets, field positions, reset values and timebase figures.
 * Assumes an 8-bit register port and a single 200 MHz system clock.
 */
package rtcirq_pkg;

	// register offsets on the 8-bit address port
	localparam logic [7:0] OFS_CTRL_A      = 8'h0A;
	localparam logic [7:0] OFS_CTRL_B      = 8'h0B;
	localparam logic [7:0] OFS_STATUS      = 8'h0C;
	localparam logic [7:0] OFS_BATTERY     = 8'h0D;
	localparam logic [7:0] OFS_RAM0_FIRST  = 8'h0E;
	localparam logic [7:0] OFS_RAM0_LAST   = 8'h7F;
	localparam logic [7:0] OFS_BANK1_FIRST = 8'h40;
	localparam logic [7:0] OFS_EXT_FLAGS   = 8'h4A;
	localparam logic [7:0] OFS_EXT_CTRL    = 8'h4B;
	localparam logic [7:0] OFS_EXT_ADDR    = 8'h50;
	localparam logic [7:0] OFS_EXT_DATA    = 8'h53;

	// user memory layout
	localparam int RAM0_BYTES = 114;
	localparam int RAM1_BYTES = 128;
	localparam int RAM_BYTES  = RAM0_BYTES + RAM1_BYTES;

	// control A fields
	localparam int CA_UIP  = 7;
	localparam int CA_DV2  = 6;
	localparam int CA_DV1  = 5;
	localparam int CA_DV0  = 4;
	localparam logic [7:0] CTRL_A_RESET = 8'h20;

	// control B fields
	localparam int CB_SET  = 7;
	localparam int CB_PIE  = 6;
	localparam int CB_AIE  = 5;
	localparam int CB_UIE  = 4;
	localparam int CB_SQUARE_WAVE_ENABLE = 3;
	localparam logic [7:0] CTRL_B_RESET = 8'h00;

	// status and battery fields
	localparam int ST_PENDING = 7;
	localparam int ST_PF      = 6;
	localparam int ST_AF      = 5;
	localparam int ST_UF      = 4;
	localparam int BAT_OK     = 7;

	// extended flag and control fields
	localparam int EF_WAKE  = 6;
	localparam int EF_KICK  = 5;
	localparam int EF_RCLR  = 3;
	localparam int EC_ABE   = 7;
	localparam int EC_FAST_CLOCK_SELECT  = 5;
	localparam int EC_WIE   = 2;
	localparam int EC_KSE   = 1;
	localparam int EC_RIE   = 0;
	localparam logic [7:0] EXT_FLAGS_RESET = 8'h00;
	localparam logic [7:0] EXT_CTRL_RESET  = 8'h00;

	// timebase: divider stage 0 toggles at twice the crystal rate
	localparam longint CLK_HZ    = 200_000_000;
	localparam longint XTAL_HZ   = 32_768;
	localparam longint TICK_HZ   = 2 * XTAL_HZ;
	localparam longint PHASE_INC = (TICK_HZ << 32) / CLK_HZ;
	localparam int     DIV_BITS  = 15;

endpackage

/* verification/rtcirq_checker_assertions.sv */
/* Checker for rtcirq_core: read data, flag and pin relations.
   Assumes it is bound to rtcirq_core and sees only its ports. */
`timescale 1ns/1ps
module rtcirq_checker
	import rtcirq_pkg::*;
(
	input wire logic       clk_in,          // clock
	input wire logic       arst_n_in,       // async reset, low
	input wire logic [7:0] addr_in,         // address
	input wire logic       wr_in,           // write strobe
	input wire logic       rd_in,           // read strobe
	input wire logic [7:0] rd_data_out,     // read data
	input wire logic       alarm_match_in,  // alarm pulse
	input wire logic       update_done_in,  // update pulse
	input wire logic       irq_n_out,       // interrupt, low
	input wire logic       osc_running_out, // oscillator on
	input wire logic       chain_reset_out  // chain held
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);
	// status read, and a cycle free of alarm and update events
	wire st = rd_in && addr_in == OFS_STATUS;
	wire quiet = !alarm_match_in && !update_done_in;
	property p_st_low; st |=> rd_data_out[3:0] == 4'h0; endproperty
	a_st_low: assert property (p_st_low)
		else $error("status low bits not zero");
	property p_bat_low;
		rd_in && addr_in == OFS_BATTERY |=> rd_data_out[6:0] == 7'h00;
	endproperty
	a_bat_low: assert property (p_bat_low)
		else $error("battery low bits not zero");
	property p_pend; st |=> rd_data_out[7] == !$past(irq_n_out); endproperty
	a_pend: assert property (p_pend)
		else $error("pending bit differs from pin");
	// a second read with no alarm or update since the first finds neither flag
	property p_clear;
		quiet [*2] ##1 (st && quiet) ##1 (!rd_in && quiet) ##1 st
			|=> rd_data_out[5:4] == 2'h0;
	endproperty
	a_clear: assert property (p_clear)
		else $error("flags survived a read");
	property p_alarm; alarm_match_in ##1 !rd_in ##1 st |=> rd_data_out[5];
	endproperty
	a_alarm: assert property (p_alarm)
		else $error("alarm flag missing");
	property p_upd; update_done_in ##1 !rd_in ##1 st |=> rd_data_out[4];
	endproperty
	a_upd: assert property (p_upd)
		else $error("update flag missing");
	property p_held; (st && alarm_match_in) ##1 !rd_in ##1 st |=> rd_data_out[5];
	endproperty
	a_held: assert property (p_held)
		else $error("event during read lost");
	property p_wrkeep;
		alarm_match_in ##1 !rd_in ##1 (wr_in && addr_in == OFS_STATUS)
			##1 !rd_in ##1 st |=> rd_data_out[5];
	endproperty
	a_wrkeep: assert property (p_wrkeep)
		else $error("status write cleared a flag");
	property p_chain; chain_reset_out |-> osc_running_out; endproperty
	a_chain: assert property (p_chain)
		else $error("chain held with oscillator off");
	c_pend: cover property (st ##1 rd_data_out[7]);
	c_held: cover property ((st && alarm_match_in) ##1 !rd_in ##1 st);
	c_chain: cover property (chain_reset_out);
endmodule
bind rtcirq_core rtcirq_checker i_rtcirq_checker (.clk_in, .arst_n_in,
	.addr_in, .wr_in, .rd_in, .rd_data_out, .alarm_match_in,
	.update_done_in, .irq_n_out, .osc_running_out, .chain_reset_out);

/* verification/rtcirq_host.sv */
/* Host processor model: one-cycle register strobes on the core port.
   Assumes one caller at a time and read data one cycle after a read. */
`timescale 1ns/1ps
module rtcirq_host (
	input  wire logic       clk_in,     // clock
	input  wire logic [7:0] rd_data_in, // read data from core
	output logic      [7:0] addr_out,   // address
	output logic      [7:0] wd_out,     // write data
	output logic            wr_out,     // write strobe
	output logic            rd_out      // read strobe
);
	// quiet bus from time zero
	initial begin
		addr_out = 8'h00;
		wd_out = 8'h00;
		wr_out = 1'b0;
		rd_out = 1'b0;
	end
	// released lines show the inverse, never a stale copy
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_in);
		wr_out <= 1'b1;
		addr_out <= a;
		wd_out <= v;
		@(posedge clk_in);
		wr_out <= 1'b0;
		addr_out <= ~a;
		wd_out <= ~v;
	endtask
	// data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		@(posedge clk_in);
		rd_out <= 1'b1;
		addr_out <= a;
		@(posedge clk_in);
		rd_out <= 1'b0;
		addr_out <= ~a;
		#1;
		q = rd_data_in;
	endtask
endmodule

/* verification/rtcirq_core_test.sv */
/* Testbench for rtcirq_core: register rows, then flag, interrupt,
   extended flag, square-wave and periodic cases.
   Assumes the host model and the checker are compiled before it. */
`timescale 1ns/1ps
module rtcirq_core_test;
	logic        clk_in;          // 200 MHz clock
	logic        arst_n_in;       // reset, low
	logic [7:0]  addr, wd, rd_data; // register port
	logic        wr, rd;          // strobes
	logic [2:0]  ev;              // alarm, update, wake pulses
	logic        bat;             // backup supply good
	logic        mains, aux;      // main and aux supply present
	logic        irq_n, square_wave_pin;      // pins
	logic        osc, chain;      // divider state
	logic [7:0]  d;               // read result
	logic        p;               // previous square-wave level
	int          err_count;       // mismatches
	int          samples_checked; // comparisons
	int          n;               // toggle count
	// address, write data, expected read, expected osc and chain
	logic [25:0] rows [13] = '{
		{8'h0A, 8'h60, 8'h60, 2'b11}, {8'h0A, 8'h40, 8'h40, 2'b00},
		{8'h0A, 8'h00, 8'h00, 2'b00}, {8'h0A, 8'hA0, 8'h20, 2'b10},
		{8'h0B, 8'h90, 8'h80, 2'b10}, {8'h0B, 8'h00, 8'h00, 2'b10},
		{8'h0C, 8'hFF, 8'h00, 2'b10}, {8'h0D, 8'h7F, 8'h80, 2'b10},
		{8'h0E, 8'h5A, 8'h5A, 2'b10}, {8'h7F, 8'hA5, 8'hA5, 2'b10},
		{8'h0A, 8'h30, 8'h30, 2'b10}, {8'h45, 8'hFF, 8'h00, 2'b10},
		{8'h0A, 8'h20, 8'h20, 2'b10}};
	// unused events and the update-busy level held quiet
	rtcirq_core i_rtcirq_core (.clk_in(clk_in), .arst_n_in(arst_n_in),
		.addr_in(addr), .wr_data_in(wd), .wr_in(wr), .rd_in(rd),
		.rd_data_out(rd_data), .alarm_match_in(ev[0]),
		.update_done_in(ev[1]), .update_in_progress_in(1'b0),
		.wake_event_in(ev[2]), .kickstart_event_in(1'b0),
		.ram_clear_event_in(1'b0), .main_power_in(mains),
		.auxiliary_supply_in(aux), .battery_good_in(bat),
		.irq_n_out(irq_n), .square_wave_pin_out(square_wave_pin),
		.osc_running_out(osc), .chain_reset_out(chain));
	rtcirq_host i_rtcirq_host (.clk_in(clk_in), .rd_data_in(rd_data),
		.addr_out(addr), .wd_out(wd), .wr_out(wr), .rd_out(rd));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic close_out;
		$display("checks=%0d errors=%0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		i_rtcirq_host.rd(a, d);
		chk(d, e);
	endtask
	task automatic w(input logic [7:0] a, input logic [7:0] v);
		i_rtcirq_host.wr(a, v);
	endtask
	// one-cycle event pulse on line k
	task automatic pulse(input int k);
		@(posedge clk_in);
		ev <= 3'b001 << k;
		@(posedge clk_in);
		ev <= 3'b000;
	endtask
	// let c edges pass, then settle
	task automatic tick(input int c);
		repeat (c) @(posedge clk_in);
		#1;
	endtask
	// count square-wave transitions over c cycles into n
	task automatic count(input int c);
		n = 0;
		p = square_wave_pin;
		repeat (c) begin
			tick(1);
			n += (square_wave_pin !== p);
			p = square_wave_pin;
		end
	endtask
	// 200 MHz clock
	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end
	// hang guard, well past the longest wait
	initial begin
		#400000;
		err_count++;
		close_out();
	end
	initial begin
		arst_n_in = 1'b0;
		ev = 3'b000;
		bat = 1'b1;
		mains = 1'b1;
		aux = 1'b0;
		err_count = 0;
		samples_checked = 0;
		repeat (8) @(posedge clk_in);
		chk({4'h0, irq_n, square_wave_pin, osc, chain}, 8'h0A);
		chk(rd_data, 8'h00);
		arst_n_in <= 1'b1;
		foreach (rows[i]) begin
			w(rows[i][25:18], rows[i][17:10]);
			rc(rows[i][25:18], rows[i][9:2]);
			chk({6'h00, osc, chain}, {6'h00, rows[i][1:0]});
		end
		// alarm and update polled without their enables
		pulse(0);
		rc(8'h0C, 8'h20);
		pulse(1);
		rc(8'h0C, 8'h10);
		rc(8'h0C, 8'h00);
		chk({7'h00, irq_n}, 8'h01);
		// a status write between event and read must not clear
		pulse(0);
		w(8'h0C, 8'hFF);
		rc(8'h0C, 8'h20);
		// event inside a read is held for the next one
		fork
			pulse(0);
			rc(8'h0C, 8'h00);
		join
		rc(8'h0C, 8'h20);
		rc(8'h0C, 8'h00);
		rc(8'h0C, 8'h00);
		// enabling a stale flag raises the pin at once
		pulse(1);
		w(8'h0B, 8'h10);
		tick(2);
		chk({7'h00, irq_n}, 8'h00);
		rc(8'h0C, 8'h90);
		tick(2);
		chk({7'h00, irq_n}, 8'h01);
		w(8'h0B, 8'h00);
		// extended flags survive reads, clear on written zero
		w(8'h0A, 8'h30);
		pulse(2);
		rc(8'h4A, 8'h40);
		w(8'h4A, 8'hFF);
		rc(8'h4A, 8'h40);
		w(8'h4B, 8'hFF);
		rc(8'h4B, 8'hA7);
		rc(8'h0C, 8'h80);
		w(8'h4A, 8'h00);
		rc(8'h4A, 8'h00);
		tick(2);
		chk({7'h00, irq_n}, 8'h01);
		// fast select alone: about four toggles in 13000 cycles
		w(8'h4B, 8'h20);
		count(13000);
		chk({7'h00, n inside {4, 5}}, 8'h01);
		// fastest periodic code, fast select still on
		w(8'h0A, 8'h23);
		w(8'h0B, 8'h40);
		i_rtcirq_host.rd(8'h0C, d);
		tick(24500);
		chk({7'h00, irq_n}, 8'h00);
		rc(8'h0C, 8'hC0);
		// both square-wave sources off
		w(8'h0B, 8'h00);
		w(8'h0A, 8'h30);
		w(8'h4B, 8'h00);
		tick(3);
		chk({7'h00, square_wave_pin}, 8'h00);
		// no main power: fast clock only with aux enable and aux supply
		@(posedge clk_in);
		mains <= 1'b0;
		aux <= 1'b1;
		w(8'h4B, 8'h20);
		count(4000);
		chk({7'h00, n == 0}, 8'h01);
		// start jump plus two or three crystal half periods
		w(8'h4B, 8'hA0);
		count(7000);
		chk({7'h00, n inside {2, 3, 4}}, 8'h01);
		@(posedge clk_in);
		mains <= 1'b1;
		aux <= 1'b0;
		w(8'h4B, 8'h00);
		// exhausted backup supply
		@(posedge clk_in);
		bat <= 1'b0;
		tick(4);
		rc(8'h0D, 8'h00);
		close_out();
	end
endmodule
